// [rtl/odt_pkg.sv]
package odt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_MODE_ONE  = 5'h00;
  localparam logic [4:0] ADDR_MODE_TWO  = 5'h04;
  localparam logic [4:0] ADDR_MODE_FIVE = 5'h08;
  localparam logic [4:0] ADDR_CONFIG    = 5'h0C;
  localparam logic [4:0] ADDR_STATUS    = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NOM_LSB       = 8;   // mode_register_one bits 10:8
  localparam int STROBE_EN_BIT = 11;  // mode_register_one bit 11
  localparam int WR_LSB        = 9;   // mode_register_two bits 10:9
  localparam int PARK_LSB      = 6;   // mode_register_five bits 8:6
  localparam int CFG_LATENCY_LSB = 0; // config bits 4:0
  localparam int CFG_WL_LSB    = 5;   // config bits 9:5
  localparam int CFG_PRE2_BIT  = 10;
  localparam int CFG_CRC_BIT   = 11;
  localparam int CFG_X8_BIT    = 12;
  localparam int CFG_BL8_BIT   = 13;

  // Writable bits of each register; all others read as zero
  localparam logic [31:0] MASK_MODE_ONE  = 32'h0000_0F00;
  localparam logic [31:0] MASK_MODE_TWO  = 32'h0000_0600;
  localparam logic [31:0] MASK_MODE_FIVE = 32'h0000_01C0;
  localparam logic [31:0] MASK_CONFIG    = 32'h0000_3FFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_MODE_ONE  = 32'h0000_0000;
  localparam logic [31:0] RESET_MODE_TWO  = 32'h0000_0000;
  localparam logic [31:0] RESET_MODE_FIVE = 32'h0000_0000;
  localparam logic [31:0] RESET_CONFIG    = 32'h0000_200B;

  // ----------------------------------------------------------------
  // Timing figures, in clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] X_ONE_CYCLE_PRE = 4'h2;
  localparam logic [3:0] X_TWO_CYCLE_PRE = 4'h3;
  localparam logic [3:0] HALF_BL8        = 4'h4;
  localparam logic [3:0] HALF_BL4        = 4'h2;
  localparam int         PIPE_DEPTH      = 32;

  // Base resistance from which every setting is divided
  localparam logic [7:0] RZQ_OHMS = 8'hF0;

  // ----------------------------------------------------------------
  // Termination states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TERM_DISABLED = 2'b00,
    TERM_WRITE    = 2'b01,
    TERM_NOMINAL  = 2'b10,
    TERM_PARK     = 2'b11
  } term_state_t;

endpackage : odt_pkg

// [rtl/odt_termination_control.sv]
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// Overview of operation
// - Four states: disabled, write, nominal, park
// - Any non-zero field enables, field sets resistance
// - Self-refresh forces termination off, high impedance
// - Write command gives write termination, pin ignored
// - Pin high turns nominal on unless disabled
// - Park applies when pin low or nominal disabled
// - Read blanks from latency-X for burst/2+X+Y
// - X is 2 or 3 by preamble
// - Y is 1 when CRC enabled
// - Priority: read, write, nominal, then park
// - Nominal disabled powers down pin receiver
// - Settings 240 down to 34 ohms
// - Apply to data, mask, strobe; x8 strobe pair
// - Pin ignored when nominal zero or self-refresh
// - Strobe pair only when its enable set
module odt_termination_control (
  // Clock and synchronous reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Command decode and pins
  input  wire logic        TERMINATION_CONTROL_PIN,
  input  wire logic        WRITE_CMD,
  input  wire logic        READ_CMD,
  input  wire logic        SELF_REFRESH,
  // Termination outputs
  output logic      [1:0]  TERM_STATE,
  output logic      [7:0]  TERM_OHMS,
  output logic             TERM_DATA_ON,
  output logic             TERM_STROBE_PAIR_ON,
  output logic             PIN_RECEIVER_EN
);

  // ----------------------------------------------------------------
  // Timing at a glance
  // ----------------------------------------------------------------
  // Bus: one wait state, then waitrequest low for one cycle
  // Bus writes commit on the edge that sees waitrequest low
  // Pin: three flops; a level counts once stages two and three agree
  // Pin change reaches the termination outputs five edges later
  // Read window opens latency minus X edges after the command
  // Write window opens after the configured write delay
  // Both windows last half the burst plus X plus Y cycles
  // Priority: self-refresh, read, write, nominal, park, off
  // Outputs follow their cause by one edge
  // One flop per delay slot, so overlapping commands each fire
  // Limitation: five-bit delay fields cap the delay at 31 cycles

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge, then drop bits the register does not hold
  function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be,
                                           input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : apply_be

  // Divisor code n selects RZQ/n; code zero means off
  // Integer division: code seven gives 34, the fraction is dropped
  function automatic logic [7:0] ohms_of(input logic [2:0] div);
    logic [7:0] r;
    r = 8'h00;
    if (div != 3'h0) begin
      r = odt_pkg::RZQ_OHMS / {5'h00, div};
    end
    return r;
  endfunction : ohms_of

  // Status layout, low to high: state, data on, receiver, ohms, self-refresh, windows
  function automatic logic [31:0] status_word(input logic [1:0] state,
                                              input logic       data_on,
                                              input logic       rx_en,
                                              input logic [7:0] ohms,
                                              input logic       in_sr,
                                              input logic       rd_win,
                                              input logic       wr_win);
    return {17'h00000, wr_win, rd_win, in_sr, ohms, rx_en, data_on, state};
  endfunction : status_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Software registers
    logic [31:0]         mode_one;
    logic [31:0]         mode_two;
    logic [31:0]         mode_five;
    logic [31:0]         config_reg;
    // Pin filter
    logic [2:0]          pin_sync;
    logic                pin_level;
    // Bus answer
    logic                waitreq;
    logic [31:0]         readdata;
    // Termination outputs
    odt_pkg::term_state_t term_state;
    logic [7:0]          ohms;
    logic                data_on;
    logic                strobe_on;
    logic                rx_en;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Mode-register fields
  logic [2:0] nom_field;
  logic [1:0] wr_field;
  logic [2:0] park_field;
  logic [4:0] read_latency;

  // Window arithmetic
  logic [3:0] x_off;
  logic [3:0] y_ext;
  logic [3:0] half_burst;
  logic [3:0] win_len;
  logic [4:0] read_delay;

  // Window outputs
  logic       read_win;
  logic       write_win;

  // Fields as the mode registers hold them
  assign nom_field    = st.mode_one[odt_pkg::NOM_LSB +: 3];
  assign wr_field     = st.mode_two[odt_pkg::WR_LSB +: 2];
  assign park_field   = st.mode_five[odt_pkg::PARK_LSB +: 3];
  assign read_latency = st.config_reg[odt_pkg::CFG_LATENCY_LSB +: 5];
  // Preamble picks X, CRC picks Y
  assign x_off        = st.config_reg[odt_pkg::CFG_PRE2_BIT] ? odt_pkg::X_TWO_CYCLE_PRE
                                                             : odt_pkg::X_ONE_CYCLE_PRE;
  assign y_ext        = {3'h0, st.config_reg[odt_pkg::CFG_CRC_BIT]};
  assign half_burst   = st.config_reg[odt_pkg::CFG_BL8_BIT] ? odt_pkg::HALF_BL8
                                                            : odt_pkg::HALF_BL4;
  // Same length for read and write windows
  assign win_len      = half_burst + x_off + y_ext;
  // Latency shorter than X would go negative, so clamp to the command cycle
  assign read_delay   = (read_latency > {1'b0, x_off}) ? (read_latency - {1'b0, x_off})
                                                       : 5'h00;

  // ----------------------------------------------------------------
  // Read blanking and write windows
  // ----------------------------------------------------------------
  // Read blanking: delay is latency minus X
  odt_window_timer u_read_window (
    .clk     (CLK),
    .reset_n (RESET_N),
    .start   (READ_CMD),
    .delay   (read_delay),
    .length  (win_len),
    .active  (read_win)
  );

  // Write window shares the read length; its delay comes from config
  odt_window_timer u_write_window (
    .clk     (CLK),
    .reset_n (RESET_N),
    .start   (WRITE_CMD),
    .delay   (st.config_reg[odt_pkg::CFG_WL_LSB +: 5]),
    .length  (win_len),
    .active  (write_win)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Working values of the resolution, not registered
  logic [2:0] sel_div;
  logic       pin_usable;
  logic       term_on;

  always_comb begin
    next_st = st;
    sel_div = 3'h0;

    // Pin synchroniser; stage one feeds stage two only
    // Stage one may be metastable, so nothing else reads it
    next_st.pin_sync = {st.pin_sync[1:0], TERMINATION_CONTROL_PIN};
    if (st.pin_sync[1] == st.pin_sync[2]) begin
      next_st.pin_level = st.pin_sync[2];
    end

    // Receiver powered down while the nominal field is zero
    next_st.rx_en = (nom_field != 3'h0);
    pin_usable    = st.pin_level && (nom_field != 3'h0) && !SELF_REFRESH;

    // Resolution, highest priority first; re-run every edge
    // Self-refresh leads: the pin receiver may be unpowered there
    if (SELF_REFRESH) begin
      next_st.term_state = odt_pkg::TERM_DISABLED;
    end else if (read_win) begin
      next_st.term_state = odt_pkg::TERM_DISABLED;
    end else if (write_win && (wr_field != 2'h0)) begin
      next_st.term_state = odt_pkg::TERM_WRITE;
      sel_div            = {1'b0, wr_field};
    end else if (pin_usable) begin
      next_st.term_state = odt_pkg::TERM_NOMINAL;
      sel_div            = nom_field;
    end else if (park_field != 3'h0) begin
      next_st.term_state = odt_pkg::TERM_PARK;
      sel_div            = park_field;
    end else begin
      next_st.term_state = odt_pkg::TERM_DISABLED;
    end

    // Off unless some field gave a non-zero setting
    term_on           = (sel_div != 3'h0);
    next_st.ohms      = ohms_of(sel_div);
    next_st.data_on   = term_on;
    // Strobe pair needs an x8 part and its enable bit
    next_st.strobe_on = term_on && st.config_reg[odt_pkg::CFG_X8_BIT]
                        && st.mode_one[odt_pkg::STROBE_EN_BIT];

    // Bus slave: one wait cycle, then answer with waitrequest low
    // Answer cycle: commit the write the master is still holding
    if (!st.waitreq) begin
      next_st.waitreq = 1'b1;
      if (AVS_WRITE) begin
        // Unmapped write addresses fall through and change nothing
        if (AVS_ADDRESS == odt_pkg::ADDR_MODE_ONE) begin
          next_st.mode_one = apply_be(st.mode_one, AVS_WRITEDATA, AVS_BYTEENABLE,
                                      odt_pkg::MASK_MODE_ONE);
        end else if (AVS_ADDRESS == odt_pkg::ADDR_MODE_TWO) begin
          next_st.mode_two = apply_be(st.mode_two, AVS_WRITEDATA, AVS_BYTEENABLE,
                                      odt_pkg::MASK_MODE_TWO);
        end else if (AVS_ADDRESS == odt_pkg::ADDR_MODE_FIVE) begin
          next_st.mode_five = apply_be(st.mode_five, AVS_WRITEDATA, AVS_BYTEENABLE,
                                       odt_pkg::MASK_MODE_FIVE);
        end else if (AVS_ADDRESS == odt_pkg::ADDR_CONFIG) begin
          next_st.config_reg = apply_be(st.config_reg, AVS_WRITEDATA, AVS_BYTEENABLE,
                                        odt_pkg::MASK_CONFIG);
        end
      end
    end else if (AVS_READ || AVS_WRITE) begin
      // Request cycle: register the answer, show it next edge
      next_st.waitreq  = 1'b0;
      next_st.readdata = 32'h0000_0000;
      // Unmapped reads return zero; unmapped writes are dropped
      if (AVS_READ) begin
        if (AVS_ADDRESS == odt_pkg::ADDR_MODE_ONE) begin
          next_st.readdata = st.mode_one;
        end else if (AVS_ADDRESS == odt_pkg::ADDR_MODE_TWO) begin
          next_st.readdata = st.mode_two;
        end else if (AVS_ADDRESS == odt_pkg::ADDR_MODE_FIVE) begin
          next_st.readdata = st.mode_five;
        end else if (AVS_ADDRESS == odt_pkg::ADDR_CONFIG) begin
          next_st.readdata = st.config_reg;
        end else if (AVS_ADDRESS == odt_pkg::ADDR_STATUS) begin
          next_st.readdata = status_word(st.term_state, st.data_on, st.rx_en, st.ohms,
                                         SELF_REFRESH, read_win, write_win);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clear all, then load the reset values of the software registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st            <= '0;
      st.mode_one   <= odt_pkg::RESET_MODE_ONE;
      st.mode_two   <= odt_pkg::RESET_MODE_TWO;
      st.mode_five  <= odt_pkg::RESET_MODE_FIVE;
      st.config_reg <= odt_pkg::RESET_CONFIG;
      // Waitrequest idles high, so no answer shows during reset
      st.waitreq    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  // Bus answer
  assign AVS_READDATA        = st.readdata;
  assign AVS_WAITREQUEST     = st.waitreq;

  // Termination state, resistance and pin enables
  assign TERM_STATE          = st.term_state;
  assign TERM_OHMS           = st.ohms;
  assign TERM_DATA_ON        = st.data_on;
  assign TERM_STROBE_PAIR_ON = st.strobe_on;
  assign PIN_RECEIVER_EN     = st.rx_en;

endmodule : odt_termination_control

// [rtl/odt_window_timer.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Delayed window: opens DELAY cycles after start, stays LENGTH cycles
// ------------------------------------------------------------------
module odt_window_timer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [4:0] delay,
  input  wire logic [3:0] length,
  output logic            active
);

  typedef struct packed {
    logic [odt_pkg::PIPE_DEPTH-2:0] pipe;  // Slot 30 serves a delay of 31
    logic [3:0]                     count;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;
  logic         trigger;

  // Every command has its own slot, so overlapping commands each fire
  always_comb begin
    next_st      = st;
    next_st.pipe = {st.pipe[odt_pkg::PIPE_DEPTH-3:0], start};
    if (delay == 5'h00) begin
      trigger = start;
    end else begin
      trigger = st.pipe[delay - 5'h01];
    end
    // A later command restarts the window rather than shortening it
    if (trigger) begin
      next_st.count = length;
    end else if (st.count != 4'h0) begin
      next_st.count = st.count - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = (st.count != 4'h0);

endmodule : odt_window_timer

// [tb/odt_ctrl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Controller side: commands, pin, self-refresh
// ----------------------------------------------------------------
module odt_ctrl_model (
  input  wire logic clk,
  output logic      pin,
  output logic      write_cmd,
  output logic      read_cmd,
  output logic      self_refresh
);
  // Quiet bus at time zero
  initial begin
    pin = 1'b0;
    write_cmd = 1'b0;
    read_cmd = 1'b0;
    self_refresh = 1'b0;
  end
  // One-cycle command, called just after an edge
  task cmd(input logic is_rd);
    if (is_rd) read_cmd <= 1'b1;
    else write_cmd <= 1'b1;
    @(posedge clk);
    read_cmd <= 1'b0;
    write_cmd <= 1'b0;
  endtask : cmd
  // Pin held at the wanted level every cycle
  task drive(input logic p, input logic s);
    pin <= p;
    self_refresh <= s;
  endtask : drive
endmodule : odt_ctrl_model

// [tb/odt_termination_control_props.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module odt_termination_control_chk (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       AVS_READ,
  input wire logic       AVS_WRITE,
  input wire logic       AVS_WAITREQUEST,
  input wire logic       TERMINATION_CONTROL_PIN,
  input wire logic       SELF_REFRESH,
  input wire logic [1:0] TERM_STATE,
  input wire logic [7:0] TERM_OHMS,
  input wire logic       TERM_DATA_ON,
  input wire logic       TERM_STROBE_PAIR_ON,
  input wire logic       PIN_RECEIVER_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Self-refresh beats every other source
  property p_sr_off;
    SELF_REFRESH |=> TERM_STATE == 2'h0 && !TERM_DATA_ON && TERM_OHMS == 8'h00;
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("termination on in self-refresh");
  // Off state never carries a resistance
  property p_off_zero;
    TERM_STATE == 2'h0 |-> !TERM_DATA_ON && TERM_OHMS == 8'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off state shows termination");
  property p_ohms;
    TERM_DATA_ON |-> TERM_OHMS inside {8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h22};
  endproperty
  a_ohms: assert property (p_ohms) else $error("resistance outside the legal set");
  property p_strobe;
    TERM_STROBE_PAIR_ON |-> TERM_DATA_ON;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pair on without data");
  property p_nom_rx;
    TERM_STATE == 2'h2 |-> PIN_RECEIVER_EN;
  endproperty
  a_nom_rx: assert property (p_nom_rx) else $error("nominal with receiver off");
  // Long low pin must drop nominal; the filter needs a few edges
  property p_nom_pin;
    !TERMINATION_CONTROL_PIN [*8] |=> TERM_STATE != 2'h2;
  endproperty
  a_nom_pin: assert property (p_nom_pin) else $error("nominal with pin low");
  property p_wait_ans;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered");
  property p_wait_pulse;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
endmodule : odt_termination_control_chk

bind odt_termination_control odt_termination_control_chk chk_u (
  .CLK(CLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .TERMINATION_CONTROL_PIN(TERMINATION_CONTROL_PIN),
  .SELF_REFRESH(SELF_REFRESH), .TERM_STATE(TERM_STATE), .TERM_OHMS(TERM_OHMS),
  .TERM_DATA_ON(TERM_DATA_ON), .TERM_STROBE_PAIR_ON(TERM_STROBE_PAIR_ON),
  .PIN_RECEIVER_EN(PIN_RECEIVER_EN));

// [tb/test_odt_termination_control.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module test_odt_termination_control;
  logic        clk, reset_n, rd_req, wr_req, waitreq, pin, wr, rd, sr;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  state;
  logic [7:0]  ohms;
  logic        data_on, pair_on, rx_en;
  int          error_cnt = 0, n_tests = 0, cyc = 0, first, len;

  odt_termination_control dut_u (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .TERMINATION_CONTROL_PIN(pin),
    .WRITE_CMD(wr), .READ_CMD(rd), .SELF_REFRESH(sr), .TERM_STATE(state),
    .TERM_OHMS(ohms), .TERM_DATA_ON(data_on), .TERM_STROBE_PAIR_ON(pair_on),
    .PIN_RECEIVER_EN(rx_en));
  odt_ctrl_model ctl_u (.clk(clk), .pin(pin), .write_cmd(wr), .read_cmd(rd),
    .self_refresh(sr));

  task wrap_up;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Avalon access; held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr_req <= w; rd_req <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    wr_req <= 1'b0; rd_req <= 1'b0;
    @(posedge clk);
  endtask : bus
  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // First cycle and length of a state after a command edge
  task cnt(input logic [1:0] s);
    first = 0; len = 0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge clk); #1;
      if (state === s) begin
        if (len == 0) first = i;
        len++;
      end
    end
    @(posedge clk);
  endtask : cnt

  task t_regs;
    bus(0, odt_pkg::ADDR_CONFIG, 0); chk(q, odt_pkg::RESET_CONFIG);
    bus(0, 5'h14, 0); chk(q, 0);
    bus(1, odt_pkg::ADDR_MODE_TWO, 32'hFFFF_FFFF);
    bus(0, odt_pkg::ADDR_MODE_TWO, 0); chk(q, odt_pkg::MASK_MODE_TWO);
    bus(1, odt_pkg::ADDR_MODE_TWO, 0);
  endtask : t_regs
  // Park codes one to seven, pin low, then pin high with nominal off
  task t_park;
    for (int n = 1; n < 8; n++) begin
      bus(1, odt_pkg::ADDR_MODE_FIVE, n << 6); settle(2);
      chk(state, odt_pkg::TERM_PARK);
      chk(ohms, 240 / n);
      chk(data_on, 1);
    end
    ctl_u.drive(1, 0); settle(8);
    chk(state, odt_pkg::TERM_PARK);
    chk(rx_en, 0);
  endtask : t_park
  task t_nominal;
    bus(1, odt_pkg::ADDR_MODE_ONE, 32'h200); settle(8);
    chk(state, odt_pkg::TERM_NOMINAL);
    chk(ohms, 120);
    chk(rx_en, 1);
    bus(0, odt_pkg::ADDR_STATUS, 0); chk(q, 32'h78E);
    ctl_u.drive(0, 0); settle(8);
    chk(state, odt_pkg::TERM_PARK);
    ctl_u.drive(1, 0); settle(8);
  endtask : t_nominal
  // Write with pin high: write wins for half burst plus X plus Y
  task t_write;
    bus(1, odt_pkg::ADDR_MODE_TWO, 32'h600); settle(2);
    ctl_u.cmd(0); cnt(odt_pkg::TERM_WRITE);
    chk(first, 1);
    chk(len, 6);
    chk(state, odt_pkg::TERM_NOMINAL);
    // Short burst, write delay 2: state follows one edge after the delay
    bus(1, odt_pkg::ADDR_CONFIG, 32'h004B); settle(2);
    ctl_u.cmd(0); cnt(odt_pkg::TERM_WRITE);
    chk(first, 3);
    chk(len, 2 + 2);
    chk(state, odt_pkg::TERM_NOMINAL);
    chk(ohms, 120);
  endtask : t_write
  // Read blank for each preamble and CRC setting
  task t_read;
    for (int k = 0; k < 4; k++) begin
      bus(1, odt_pkg::ADDR_CONFIG, 32'h200B | (k << 10)); settle(2);
      ctl_u.cmd(1); cnt(odt_pkg::TERM_DISABLED);
      chk(first, 11 - (2 + k % 2) + 1);
      chk(len, 4 + (2 + k % 2) + k / 2);
    end
  endtask : t_read
  task t_sr_pair;
    bus(1, odt_pkg::ADDR_CONFIG, 32'h300B);
    bus(1, odt_pkg::ADDR_MODE_ONE, 32'hA00); settle(2);
    chk(pair_on, 1);
    ctl_u.drive(1, 1); settle(3);
    chk(state, odt_pkg::TERM_DISABLED);
    chk(pair_on, 0);
    bus(0, odt_pkg::ADDR_STATUS, 0); chk(q[12], 1);
    ctl_u.drive(1, 0);
    bus(1, odt_pkg::ADDR_MODE_ONE, 32'h200); settle(2);
    chk(pair_on, 0);
  endtask : t_sr_pair

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    reset_n = 1'b0; rd_req = 1'b0; wr_req = 1'b0; addr = 5'h00; wdata = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs; t_park; t_nominal; t_write; t_read; t_sr_pair;
    wrap_up;
  end
endmodule : test_odt_termination_control
